// >>> logic/mhbs_defs.svh
// Constants for the motor holding brake sequencer: offsets, fields, reset values, timing
`ifndef MHBS_DEFS_SVH
`define MHBS_DEFS_SVH

// Clock and timer tick
`define MHBS_CLK_PERIOD_NS 20
`define MHBS_TICK_NS 1000000
`define MHBS_TMR_W 19

// Register byte offsets
`define MHBS_OFS_CTRL 8'h00
`define MHBS_OFS_MAGNET 8'h04
`define MHBS_OFS_OPEN 8'h08
`define MHBS_OFS_CLOSE 8'h0c
`define MHBS_OFS_THRESH 8'h10
`define MHBS_OFS_MONITOR 8'h14
`define MHBS_OFS_PULSE 8'h18
`define MHBS_OFS_START_FREQ 8'h1c
`define MHBS_OFS_MODE 8'h20
`define MHBS_OFS_BOOST 8'h24
`define MHBS_OFS_STATUS 8'h28

// Control register fields
`define MHBS_CTRL_SEL_LSB 0
`define MHBS_CTRL_SEL_MSB 1
`define MHBS_CTRL_FOPEN 2
`define MHBS_CTRL_FCLOSE 3
`define MHBS_CTRL_TSRC 4
`define MHBS_CTRL_W 5

// Brake function select codes
`define MHBS_SEL_OFF 2'h0
`define MHBS_SEL_SEQ 2'h1
`define MHBS_SEL_OPEN 2'h2
`define MHBS_SEL_LINK 2'h3

// Control mode limits
`define MHBS_MODE_UF_MAX 8'h03
`define MHBS_MODE_VEC_MIN 8'h14

// Reset values, times in milliseconds
`define MHBS_RST_CTRL 5'h00
`define MHBS_RST_MAGNET 19'h00000
`define MHBS_RST_OPEN 19'h00064
`define MHBS_RST_CLOSE 19'h00064
`define MHBS_RST_THRESH 16'h0014
`define MHBS_RST_MONITOR 19'h493e0
`define MHBS_RST_PULSE 19'h0000a
`define MHBS_RST_START_FREQ 16'h0000
`define MHBS_RST_MODE 8'h00
`define MHBS_RST_BOOST 16'h0000

`endif

// >>> logic/mhbs_pkg.sv
// Types for the motor holding brake sequencer
package mhbs_pkg;
  typedef enum logic [2:0] {
    MHBS_OFF = 3'b000,
    MHBS_MAGNETIZE = 3'b001,
    MHBS_OPENING = 3'b010,
    MHBS_RUN = 3'b011,
    MHBS_STOPPING = 3'b100,
    MHBS_CLOSING = 3'b101
  } mhbs_state_t;
endpackage

// >>> logic/mhbs_timer.sv
// Millisecond interval timer used for every delay of the brake sequence
`timescale 1ns/10ps
`include "mhbs_defs.svh"
module mhbs_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic run,
  input wire logic [`MHBS_TMR_W-1:0] limit,
  output logic expired
);
  logic [`MHBS_TMR_W:0] cnt_q;

  // Count ticks while running; dropping run restarts from zero
  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      cnt_q <= '0;
    end else if (tick && !expired) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Strictly above the limit, so the delay is never shorter than set
  assign expired = run && (cnt_q > {1'b0, limit});
endmodule

// >>> logic/mhbs_sequencer.sv
// Motor holding brake sequencer with Avalon-MM register slave
// Functional notes
// - Magnetize first, then open brake
// - Hold zero speed for opening delay, then ramp
// - Ramped or quick stop decelerates motor
// - Setpoint below threshold starts monitor timer
// - Actual speed below threshold starts pulse timer
// - First expiring standstill timer closes brake
// - Keep motor energized for closing delay
// - Coast stop or torque off closes immediately
// - Decode brake function select zero to three
// - Forced open input overrides sequence
// - Forced close input overrides sequence
// - Nonzero start frequency enables slip compensation
// - Vector mode torque from selectable source
// - Control mode picks boost or torque
`timescale 1ns/10ps
`include "mhbs_defs.svh"
module mhbs_sequencer #(
  parameter int TICK_CYCLES = `MHBS_TICK_NS / `MHBS_CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_cmd,
  input wire logic ramp_stop_cmd,
  input wire logic quick_stop_cmd,
  input wire logic coast_stop_cmd,
  input wire logic safe_torque_off,
  input wire logic forced_brake_open_input,
  input wire logic forced_brake_close_input,
  input wire logic [15:0] speed_setpoint,
  input wire logic [15:0] actual_speed,
  input wire logic [15:0] brake_start_torque_source,
  output logic brake_relay_open,
  output logic brake_interconnect_open,
  output logic motor_on,
  output logic magnetize,
  output logic hold_zero_speed,
  output logic ramp_enable,
  output logic ramp_down,
  output logic quick_ramp,
  output logic slip_comp_enable,
  output logic [15:0] slip_comp_value,
  output logic [15:0] voltage_boost,
  output logic [15:0] torque_setpoint
);
  localparam int T_MAG = 0;
  localparam int T_OPEN = 1;
  localparam int T_CLOSE = 2;
  localparam int T_MON = 3;
  localparam int T_PULSE = 4;
  localparam int N_TMR = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`MHBS_CTRL_W-1:0] ctrl_q;
  logic [`MHBS_TMR_W-1:0] magnetizing_time_q;
  logic [`MHBS_TMR_W-1:0] brake_open_delay_q;
  logic [`MHBS_TMR_W-1:0] brake_close_delay_q;
  logic [15:0] standstill_speed_threshold_q;
  logic [`MHBS_TMR_W-1:0] standstill_monitor_time_q;
  logic [`MHBS_TMR_W-1:0] pulse_removal_delay_q;
  logic [15:0] brake_start_frequency_q;
  logic [7:0] control_mode_select_q;
  logic [15:0] start_voltage_boost_q;
  logic ack_q;
  logic [31:0] rdata_q;
  mhbs_pkg::mhbs_state_t st_q;
  mhbs_pkg::mhbs_state_t st_d;
  logic open_cmd_q;
  logic [1:0] brake_function_select;
  logic wr_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle for every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign wr_en = avs_write && ack_q;
  assign brake_function_select = ctrl_q[`MHBS_CTRL_SEL_MSB:`MHBS_CTRL_SEL_LSB];

  // Acknowledge toggles so back-to-back requests each get their wait cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Read data captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        `MHBS_OFS_CTRL: rdata_q <= {27'h0, ctrl_q};
        `MHBS_OFS_MAGNET: rdata_q <= {13'h0, magnetizing_time_q};
        `MHBS_OFS_OPEN: rdata_q <= {13'h0, brake_open_delay_q};
        `MHBS_OFS_CLOSE: rdata_q <= {13'h0, brake_close_delay_q};
        `MHBS_OFS_THRESH: rdata_q <= {16'h0, standstill_speed_threshold_q};
        `MHBS_OFS_MONITOR: rdata_q <= {13'h0, standstill_monitor_time_q};
        `MHBS_OFS_PULSE: rdata_q <= {13'h0, pulse_removal_delay_q};
        `MHBS_OFS_START_FREQ: rdata_q <= {16'h0, brake_start_frequency_q};
        `MHBS_OFS_MODE: rdata_q <= {24'h0, control_mode_select_q};
        `MHBS_OFS_BOOST: rdata_q <= {16'h0, start_voltage_boost_q};
        `MHBS_OFS_STATUS: rdata_q <= {27'h0, motor_on, open_cmd_q, st_q};
        default: rdata_q <= 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  // Register writes land at the edge where waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q <= `MHBS_RST_CTRL;
      magnetizing_time_q <= `MHBS_RST_MAGNET;
      brake_open_delay_q <= `MHBS_RST_OPEN;
      brake_close_delay_q <= `MHBS_RST_CLOSE;
      standstill_speed_threshold_q <= `MHBS_RST_THRESH;
      standstill_monitor_time_q <= `MHBS_RST_MONITOR;
      pulse_removal_delay_q <= `MHBS_RST_PULSE;
      brake_start_frequency_q <= `MHBS_RST_START_FREQ;
      control_mode_select_q <= `MHBS_RST_MODE;
      start_voltage_boost_q <= `MHBS_RST_BOOST;
    end else if (wr_en) begin
      unique case (avs_address)
        `MHBS_OFS_CTRL: ctrl_q <= avs_writedata[`MHBS_CTRL_W-1:0];
        `MHBS_OFS_MAGNET: magnetizing_time_q <= avs_writedata[`MHBS_TMR_W-1:0];
        `MHBS_OFS_OPEN: brake_open_delay_q <= avs_writedata[`MHBS_TMR_W-1:0];
        `MHBS_OFS_CLOSE: brake_close_delay_q <= avs_writedata[`MHBS_TMR_W-1:0];
        `MHBS_OFS_THRESH: standstill_speed_threshold_q <= avs_writedata[15:0];
        `MHBS_OFS_MONITOR: standstill_monitor_time_q <= avs_writedata[`MHBS_TMR_W-1:0];
        `MHBS_OFS_PULSE: pulse_removal_delay_q <= avs_writedata[`MHBS_TMR_W-1:0];
        `MHBS_OFS_START_FREQ: brake_start_frequency_q <= avs_writedata[15:0];
        `MHBS_OFS_MODE: control_mode_select_q <= avs_writedata[7:0];
        `MHBS_OFS_BOOST: start_voltage_boost_q <= avs_writedata[15:0];
        default: ; // Status and unmapped words ignore writes
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Safety pins: three stages, a change counts once stages two and three agree
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_q;
  logic kill;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q <= 2'h0;
    end else begin
      pin_s1_q <= {safe_torque_off, coast_stop_cmd};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  assign kill = |pin_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and the five sequence timers
  logic [15:0] div_q;
  logic tick;
  logic [N_TMR-1:0] tmr_run;
  logic [N_TMR-1:0] tmr_exp;
  logic [`MHBS_TMR_W-1:0] tmr_lim [N_TMR];
  logic sp_below_q;
  logic act_below_q;

  // Free-running divider gives the one-cycle tick enable
  always_ff @(posedge sys_clk) begin
    if (!nrst || tick) begin
      div_q <= 16'h0;
    end else begin
      div_q <= div_q + 16'h1;
    end
  end

  assign tick = (div_q == 16'(TICK_CYCLES - 1));

  // Each timer runs only in its own state, so leaving the state cancels it
  assign tmr_run[T_MAG] = (st_q == mhbs_pkg::MHBS_MAGNETIZE);
  assign tmr_run[T_OPEN] = (st_q == mhbs_pkg::MHBS_OPENING);
  assign tmr_run[T_CLOSE] = (st_q == mhbs_pkg::MHBS_CLOSING);
  assign tmr_run[T_MON] = (st_q == mhbs_pkg::MHBS_STOPPING) && sp_below_q;
  assign tmr_run[T_PULSE] = (st_q == mhbs_pkg::MHBS_STOPPING) && act_below_q;
  assign tmr_lim[T_MAG] = magnetizing_time_q;
  assign tmr_lim[T_OPEN] = brake_open_delay_q;
  assign tmr_lim[T_CLOSE] = brake_close_delay_q;
  assign tmr_lim[T_MON] = standstill_monitor_time_q;
  assign tmr_lim[T_PULSE] = pulse_removal_delay_q;

  for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
    mhbs_timer u_tmr (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(tick),
      .run(tmr_run[i]),
      .limit(tmr_lim[i]),
      .expired(tmr_exp[i])
    );
  end

  // Standstill detection latches; once below, stays below until the stop ends
  always_ff @(posedge sys_clk) begin
    if (!nrst || st_q != mhbs_pkg::MHBS_STOPPING) begin
      sp_below_q <= 1'b0;
      act_below_q <= 1'b0;
    end else begin
      sp_below_q <= sp_below_q || (speed_setpoint < standstill_speed_threshold_q);
      act_below_q <= act_below_q || (actual_speed < standstill_speed_threshold_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence state machine
  logic stop_req;
  logic brake_seq;

  assign stop_req = !run_cmd || ramp_stop_cmd || quick_stop_cmd;
  // Select 0 and 2 skip the opening and closing delays: no sequenced brake
  assign brake_seq = (brake_function_select == `MHBS_SEL_SEQ) || (brake_function_select == `MHBS_SEL_LINK);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      mhbs_pkg::MHBS_OFF: begin
        if (run_cmd && !stop_req) begin
          st_d = mhbs_pkg::MHBS_MAGNETIZE;
        end
      end
      mhbs_pkg::MHBS_MAGNETIZE: begin
        if (stop_req) begin
          st_d = mhbs_pkg::MHBS_OFF;
        end else if (tmr_exp[T_MAG]) begin
          st_d = brake_seq ? mhbs_pkg::MHBS_OPENING : mhbs_pkg::MHBS_RUN;
        end
      end
      mhbs_pkg::MHBS_OPENING: begin
        if (stop_req) begin
          st_d = mhbs_pkg::MHBS_CLOSING;
        end else if (tmr_exp[T_OPEN]) begin
          st_d = mhbs_pkg::MHBS_RUN;
        end
      end
      mhbs_pkg::MHBS_RUN: begin
        if (stop_req) begin
          st_d = mhbs_pkg::MHBS_STOPPING;
        end
      end
      mhbs_pkg::MHBS_STOPPING: begin
        if (tmr_exp[T_MON] || tmr_exp[T_PULSE]) begin
          st_d = brake_seq ? mhbs_pkg::MHBS_CLOSING : mhbs_pkg::MHBS_OFF;
        end
      end
      mhbs_pkg::MHBS_CLOSING: begin
        if (tmr_exp[T_CLOSE]) begin
          st_d = mhbs_pkg::MHBS_OFF;
        end
      end
      default: st_d = mhbs_pkg::MHBS_OFF;
    endcase
    // Coast stop and torque off win over every state and drop every timer
    if (kill) begin
      st_d = mhbs_pkg::MHBS_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q <= mhbs_pkg::MHBS_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Brake command: kill, then forced close, then forced open, then select code
  logic fclose;
  logic fopen;
  logic seq_open;
  logic open_cmd_d;

  assign fclose = forced_brake_close_input || ctrl_q[`MHBS_CTRL_FCLOSE];
  assign fopen = forced_brake_open_input || ctrl_q[`MHBS_CTRL_FOPEN];
  assign seq_open = brake_seq && (st_d == mhbs_pkg::MHBS_OPENING || st_d == mhbs_pkg::MHBS_RUN
                    || st_d == mhbs_pkg::MHBS_STOPPING);

  always_comb begin
    if (kill || fclose) begin
      open_cmd_d = 1'b0;
    end else if (fopen || brake_function_select == `MHBS_SEL_OPEN) begin
      open_cmd_d = 1'b1;
    end else begin
      open_cmd_d = seq_open;
    end
  end

  // Select 3 routes the command to the interconnect instead of the relay
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      open_cmd_q <= 1'b0;
      brake_relay_open <= 1'b0;
      brake_interconnect_open <= 1'b0;
    end else begin
      open_cmd_q <= open_cmd_d;
      brake_relay_open <= open_cmd_d && (brake_function_select != `MHBS_SEL_LINK);
      brake_interconnect_open <= open_cmd_d && (brake_function_select == `MHBS_SEL_LINK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive-side outputs follow the next state so they line up with the brake
  logic uf_mode;
  logic vec_mode;
  logic starting;

  assign uf_mode = control_mode_select_q <= `MHBS_MODE_UF_MAX;
  assign vec_mode = control_mode_select_q >= `MHBS_MODE_VEC_MIN;
  assign starting = (st_d == mhbs_pkg::MHBS_OPENING);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      motor_on <= 1'b0;
      magnetize <= 1'b0;
      hold_zero_speed <= 1'b0;
      ramp_enable <= 1'b0;
      ramp_down <= 1'b0;
      quick_ramp <= 1'b0;
    end else begin
      motor_on <= (st_d != mhbs_pkg::MHBS_OFF);
      magnetize <= (st_d == mhbs_pkg::MHBS_MAGNETIZE);
      hold_zero_speed <= (st_d == mhbs_pkg::MHBS_OPENING) || (st_d == mhbs_pkg::MHBS_CLOSING);
      ramp_enable <= (st_d == mhbs_pkg::MHBS_RUN);
      ramp_down <= (st_d == mhbs_pkg::MHBS_STOPPING);
      quick_ramp <= (st_d == mhbs_pkg::MHBS_STOPPING) && quick_stop_cmd;
    end
  end

  // Start boost by control mode; unconnected torque source reads as zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slip_comp_enable <= 1'b0;
      slip_comp_value <= 16'h0;
      voltage_boost <= 16'h0;
      torque_setpoint <= 16'h0;
    end else begin
      slip_comp_enable <= (brake_start_frequency_q != 16'h0);
      slip_comp_value <= (starting && uf_mode) ? brake_start_frequency_q : 16'h0;
      voltage_boost <= (starting && uf_mode) ? start_voltage_boost_q : 16'h0;
      torque_setpoint <= (starting && vec_mode && ctrl_q[`MHBS_CTRL_TSRC]) ? brake_start_torque_source : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_no_open_magnet: assert property (@(posedge sys_clk) disable iff (!nrst)
    magnetize && !$past(fopen) && $past(brake_function_select) != `MHBS_SEL_OPEN
    |-> !brake_relay_open && !brake_interconnect_open)
    else $error("brake opened during magnetizing");

  a_open_after_magnet: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_MAGNETIZE && tmr_exp[T_MAG] && !stop_req && !kill && !fclose && brake_seq
    |=> st_q == mhbs_pkg::MHBS_OPENING && open_cmd_q)
    else $error("brake not opened after magnetizing");

  a_hold_then_ramp: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_OPENING |-> hold_zero_speed && !ramp_enable)
    else $error("ramp released during opening delay");

  a_stop_decel: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_RUN && stop_req && !kill |=> ramp_down && motor_on)
    else $error("stop did not decelerate");

  a_monitor_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_STOPPING && speed_setpoint < standstill_speed_threshold_q && !kill
    && !tmr_exp[T_PULSE] && !tmr_exp[T_MON] |=> tmr_run[T_MON])
    else $error("monitor timer not started");

  a_pulse_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_STOPPING && actual_speed < standstill_speed_threshold_q && !kill
    && !tmr_exp[T_MON] && !tmr_exp[T_PULSE] |=> tmr_run[T_PULSE])
    else $error("pulse removal timer not started");

  a_close_first_timer: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == mhbs_pkg::MHBS_STOPPING && (tmr_exp[T_MON] || tmr_exp[T_PULSE]) && !fopen
    && brake_function_select != `MHBS_SEL_OPEN |=> !open_cmd_q)
    else $error("brake not closed at standstill");

  a_energized_closing: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(st_q == mhbs_pkg::MHBS_CLOSING) && !kill |=> motor_on && hold_zero_speed)
    else $error("motor dropped during closing delay");

  a_kill_closes: assert property (@(posedge sys_clk) disable iff (!nrst)
    kill |=> !open_cmd_q && !brake_relay_open && !motor_on && st_q == mhbs_pkg::MHBS_OFF)
    else $error("coast stop did not close brake");

  a_kill_timers: assert property (@(posedge sys_clk) disable iff (!nrst)
    kill |=> tmr_run == '0)
    else $error("timer still running after coast stop");

  a_select_open: assert property (@(posedge sys_clk) disable iff (!nrst)
    brake_function_select == `MHBS_SEL_OPEN && !kill && !fclose |=> brake_relay_open)
    else $error("permanent open not applied");

  a_forced_open: assert property (@(posedge sys_clk) disable iff (!nrst)
    forced_brake_open_input && !kill && !fclose |=> open_cmd_q)
    else $error("forced open ignored");

  a_forced_close: assert property (@(posedge sys_clk) disable iff (!nrst)
    fclose |=> !brake_relay_open && !brake_interconnect_open)
    else $error("forced close ignored");

  a_slip_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
    ##1 slip_comp_enable == ($past(brake_start_frequency_q) != 16'h0))
    else $error("slip compensation enable wrong");
endmodule

// >>> tb/mhbs_brake_model.sv
// Brake relay and holding brake model with release and engage lag
`timescale 1ns/10ps
module mhbs_brake_model #(
  parameter int REL_CYC = 20,
  parameter int ENG_CYC = 15
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic open_cmd,
  output logic released
);
  int cnt_q;
  // Brake follows the coil only after its mechanical time, never at once
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      released <= 1'b0;
      cnt_q <= 0;
    end else if (released == open_cmd) begin
      cnt_q <= 0;
    end else if (cnt_q >= (open_cmd ? REL_CYC : ENG_CYC) - 1) begin
      released <= open_cmd;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// >>> tb/mhbs_sequencer_test.sv
// Self-checking bench for the brake sequencer with a brake model
`timescale 1ns/10ps
`include "mhbs_defs.svh"
module mhbs_sequencer_test;
  logic sys_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, run_cmd = 0, ramp_stop_cmd = 0;
  logic quick_stop_cmd = 0, coast_stop_cmd = 0, safe_torque_off = 0, forced_brake_open_input = 0;
  logic forced_brake_close_input = 0, avs_waitrequest, brake_relay_open, brake_interconnect_open;
  logic motor_on, magnetize, hold_zero_speed, ramp_enable, ramp_down, quick_ramp, slip_comp_enable;
  logic released;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic [15:0] speed_setpoint = 0, actual_speed = 0, brake_start_torque_source = 0;
  logic [15:0] slip_comp_value, voltage_boost, torque_setpoint;
  logic [31:0] exp_q[$];
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  logic [7:0] ofs[6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h3c};
  logic [31:0] rv[6] = '{32'h64, 32'h64, 32'h14, 32'h493e0, 32'ha, 32'h0};
  logic [15:0] boost, freq;

  mhbs_sequencer #(.TICK_CYCLES(10)) dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_cmd(run_cmd), .ramp_stop_cmd(ramp_stop_cmd),
    .quick_stop_cmd(quick_stop_cmd), .coast_stop_cmd(coast_stop_cmd), .safe_torque_off(safe_torque_off),
    .forced_brake_open_input(forced_brake_open_input), .forced_brake_close_input(forced_brake_close_input),
    .speed_setpoint(speed_setpoint), .actual_speed(actual_speed),
    .brake_start_torque_source(brake_start_torque_source), .brake_relay_open(brake_relay_open),
    .brake_interconnect_open(brake_interconnect_open), .motor_on(motor_on), .magnetize(magnetize),
    .hold_zero_speed(hold_zero_speed), .ramp_enable(ramp_enable), .ramp_down(ramp_down),
    .quick_ramp(quick_ramp), .slip_comp_enable(slip_comp_enable), .slip_comp_value(slip_comp_value),
    .voltage_boost(voltage_boost), .torque_setpoint(torque_setpoint));
  mhbs_brake_model brake (.sys_clk(sys_clk), .nrst(nrst), .open_cmd(brake_relay_open), .released(released));

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Counts edges until the signal reaches the level; the global timeout bounds it
  task automatic wait_sig(ref logic s, input logic v, output int cnt);
    cnt = 0;
    while (s !== v) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask

  task automatic inr(input int v, input int lo, input int hi);
    check(v >= lo && v <= hi, 1'b1);
  endtask

  // Read data checked against the oldest note when the slave answers
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
  end

  // Hang guard: the whole run needs about 1000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'h527611ea));
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    $display("Test reset values done");
    boost = 16'($urandom_range(1, 16'hffff));
    freq = 16'($urandom_range(1, 16'hffff));
    brake_start_torque_source <= 16'($urandom);
    // Magnetizing time goes in before the brake function is enabled
    bus(1'b1, `MHBS_OFS_MAGNET, 32'h2);
    bus(1'b1, `MHBS_OFS_CTRL, 32'h1);
    bus(1'b1, `MHBS_OFS_OPEN, 32'h3);
    bus(1'b1, `MHBS_OFS_CLOSE, 32'h3);
    bus(1'b1, `MHBS_OFS_PULSE, 32'h2);
    bus(1'b1, `MHBS_OFS_MONITOR, 32'h28);
    // Ramped stop ends on the monitor timer, quick stop on the pulse timer
    for (int k = 0; k < 2; k++) begin
      run_cmd <= 1'b1;
      wait_sig(magnetize, 1'b1, n);
      check(brake_relay_open, 1'b0);
      wait_sig(brake_relay_open, 1'b1, n);
      inr(n, 18, 32);
      check(hold_zero_speed, 1'b1);
      wait_sig(ramp_enable, 1'b1, n);
      inr(n, 28, 42);
      check(released, 1'b1);
      rd(`MHBS_OFS_STATUS, 32'h1b);
      if (k == 0) ramp_stop_cmd <= 1'b1;
      else quick_stop_cmd <= 1'b1;
      speed_setpoint <= (k == 0) ? 16'($urandom_range(0, 19)) : 16'd500;
      actual_speed <= (k == 0) ? 16'd500 : 16'($urandom_range(0, 19));
      wait_sig(ramp_down, 1'b1, n);
      check(quick_ramp, k[0]);
      check(motor_on, 1'b1);
      wait_sig(brake_relay_open, 1'b0, n);
      if (k == 0) inr(n, 395, 425);
      else inr(n, 18, 35);
      check(motor_on, 1'b1);
      wait_sig(motor_on, 1'b0, n);
      inr(n, 28, 42);
      check(released, 1'b0);
      run_cmd <= 1'b0;
      ramp_stop_cmd <= 1'b0;
      quick_stop_cmd <= 1'b0;
      @(posedge sys_clk);
      $display("Test stop kind %0d done", k);
    end
    // Coast stop then torque off, each while running
    for (int j = 0; j < 2; j++) begin
      run_cmd <= 1'b1;
      wait_sig(ramp_enable, 1'b1, n);
      if (j == 0) coast_stop_cmd <= 1'b1;
      else safe_torque_off <= 1'b1;
      wait_sig(brake_relay_open, 1'b0, n);
      inr(n, 1, 6);
      check(motor_on, 1'b0);
      run_cmd <= 1'b0;
      coast_stop_cmd <= 1'b0;
      safe_torque_off <= 1'b0;
      repeat (8) @(posedge sys_clk);
      $display("Test kill kind %0d done", j);
    end
    bus(1'b1, `MHBS_OFS_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    check(brake_relay_open, 1'b1);
    bus(1'b1, `MHBS_OFS_CTRL, 32'ha);
    repeat (3) @(posedge sys_clk);
    check(brake_relay_open, 1'b0);
    bus(1'b1, `MHBS_OFS_CTRL, 32'h0);
    forced_brake_open_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(brake_relay_open, 1'b1);
    forced_brake_open_input <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(brake_relay_open, 1'b0);
    $display("Test select and forced done");
    bus(1'b1, `MHBS_OFS_CTRL, 32'h3);
    bus(1'b1, `MHBS_OFS_BOOST, {16'h0, boost});
    bus(1'b1, `MHBS_OFS_START_FREQ, {16'h0, freq});
    repeat (2) @(posedge sys_clk);
    check(slip_comp_enable, 1'b1);
    run_cmd <= 1'b1;
    wait_sig(brake_interconnect_open, 1'b1, n);
    check(brake_relay_open, 1'b0);
    check(voltage_boost, boost);
    check(slip_comp_value, freq);
    check(torque_setpoint, 16'h0);
    $display("Test interconnect start done");
    // Vector mode start takes torque from the connected source, no boost
    run_cmd <= 1'b0;
    wait_sig(motor_on, 1'b0, n);
    bus(1'b1, `MHBS_OFS_MODE, {24'h0, `MHBS_MODE_VEC_MIN});
    bus(1'b1, `MHBS_OFS_CTRL, 32'h13);
    run_cmd <= 1'b1;
    wait_sig(brake_interconnect_open, 1'b1, n);
    check(torque_setpoint, brake_start_torque_source);
    check(voltage_boost, 16'h0);
    check(slip_comp_value, 16'h0);
    $display("Test vector start done");
    complete_run();
  end
endmodule
